// [spb_pkg.sv]
// Package: register map, field layout and carrier types of the serial port
package spb_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] SPB_RX_DATA_OFS = 16'h6040; // rx_data_register
  localparam logic [15:0] SPB_TX_DATA_OFS = 16'h6044; // tx_data_register
  localparam logic [15:0] SPB_MAIN_CTL_OFS = 16'h6048; // main_control_register
  localparam logic [15:0] SPB_SEL_CTL_OFS = 16'h604c; // slave_select_control
  localparam logic [15:0] SPB_WAIT_OFS = 16'h6050; // transfer_wait_count
  localparam logic [15:0] SPB_STAT_OFS = 16'h6054; // transfer_status
  localparam logic [15:0] SPB_INT_OFS = 16'h6058; // interrupt_control
  localparam logic [15:0] SPB_MASK_OFS = 16'h605c; // receive_data_mask

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SPB_ENA_BIT = 0; // module_enable_bit
  localparam int SPB_MODE_BIT = 1; // Master when set
  localparam int SPB_RATE_LSB = 4; // clock_rate_field [6:4]
  localparam int SPB_CPOL_BIT = 8; // Clock idle level
  localparam int SPB_CPHA_BIT = 9; // Clock phase
  localparam int SPB_LEN_LSB = 10; // bit_length_field [13:10]
  localparam int SPB_SSC_BIT = 8; // select_pin_enable
  localparam int SPB_SSP_BIT = 9; // select_polarity_bit
  localparam int SPB_SS_BIT = 10; // Software select
  localparam int SPB_BUSY_BIT = 6; // transfer_busy_flag
  localparam int SPB_TX_EMPTY_FLAG_BIT = 4; // tx_empty_flag
  localparam int SPB_RX_OVERWRITE_FLAG_BIT = 3; // rx_overwrite_flag
  localparam int SPB_RX_FULL_FLAG_BIT = 2; // rx_full_flag
  localparam int SPB_TX_EMPTY_IRQ_ENABLE_BIT = 4; // tx_empty_irq_enable
  localparam int SPB_RX_OVERWRITE_IRQ_ENABLE_BIT = 3; // rx_overwrite_irq_enable
  localparam int SPB_RX_FULL_IRQ_ENABLE_BIT = 2; // rx_full_irq_enable
  localparam int SPB_SIRQ_BIT = 1; // soft_irq_request
  localparam int SPB_IRQ_MASTER_ENABLE_BIT = 0; // irq_master_enable
  localparam int SPB_RX_MASK_ENABLE_BIT = 1; // rx_mask_enable
  localparam int SPB_RXMK_LSB = 10; // rx_valid_bits_field [14:10]

  // ----------------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] SPB_MAIN_CTL_WMASK = 16'h7f73;
  localparam logic [15:0] SPB_SEL_CTL_WMASK = 16'h0700;
  localparam logic [15:0] SPB_INT_WMASK = 16'h001f;
  localparam logic [15:0] SPB_MASK_WMASK = 16'h7c02;
  localparam logic [15:0] SPB_CTL_RST = 16'h0000;
  localparam logic SPB_TX_EMPTY_FLAG_RST = 1'b1;

  // ----------------------------------------------------------------------
  // Timing: serial clock half period is 2 << rate peripheral clocks
  // ----------------------------------------------------------------------
  localparam logic [8:0] SPB_HALF_BASE = 9'h002;
  localparam int SPB_PERIOD_SHIFT = 2; // Full period is 4 << rate

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr; // Byte address
    logic [15:0] wdata; // Write data
    logic wr; // Write strobe
    logic rd; // Read strobe
  } spb_bus_t;

  typedef struct packed {
    logic sclk; // serial_clock from a master
    logic sdi; // Serial data in
    logic ss; // slave_select_pin
  } spb_pin_in_t;

  typedef struct packed {
    logic sclk; // serial_clock driven in master mode
    logic sclk_oe; // High while the clock pin is driven
    logic sdo; // Serial data out
  } spb_pin_out_t;

endpackage : spb_pkg

// [spb_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module spb_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] synced
);

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_q; // First stage, read only by the second

  // One lane per bit; lanes are independent levels
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q[i] <= 1'b0;
          synced[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= raw[i];
          synced[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : spb_sync

// [spb_core.sv]
// Serial port block: registers, transfer engine, flags and interrupt request
`timescale 1ns/100ps
// Overview of operation
// - Software select bit sets slave selection
// - Polarity bit: 1 high, 0 low select
// - Pin enable takes selection from pin
// - Master waits wait-field serial clocks between words
// - Busy flag shows master transfer in progress
// - Tx empty clears on write, sets on load
// - Receive while full overwrites, sets overwrite
// - Rx full sets on word end, clears read/disable
// - Three cause enables, reset disabled
// - Master enable gates interrupt request
// - Software request bit raises/withdraws interrupt
// - Masked read keeps bits 0..N only
// - Mask enable switches masking on
// - Enable bit starts, clearing stops module
// - Word length is field plus one
// - Master clock is pclk over 4*2^rate
// - Mode bit: 1 master, 0 slave
module spb_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire spb_pkg::spb_bus_t bus,
  output logic [15:0] rdata,
  input wire spb_pkg::spb_pin_in_t sense,
  output spb_pkg::spb_pin_out_t drive,
  output logic irq
);
  import spb_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Address match, used by every register decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  // Ones in bits 0..n, saturating at sixteen bits
  function automatic logic [15:0] low_mask(input logic [4:0] n);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++)
      m[i] = (5'(i) <= n);
    low_mask = m;
  endfunction : low_mask

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_XFER, M_WAIT} spb_mst_t;
  spb_mst_t st_q; // Master sequencer
  logic [15:0] ctl_q; // main_control_register
  logic [15:0] sel_q; // slave_select_control
  logic [15:0] wait_q; // transfer_wait_count
  logic [15:0] int_q; // interrupt_control
  logic [15:0] msk_q; // receive_data_mask
  logic [15:0] txb_q; // Transmit buffer
  logic [15:0] rxb_q; // Receive buffer
  logic [15:0] sh_q; // Tx shift register, MSB goes out
  logic [15:0] rx_q; // Rx shift register
  logic tx_empty_flag_q; // tx_empty_flag
  logic rx_full_flag_q; // rx_full_flag
  logic rx_overwrite_flag_q; // rx_overwrite_flag
  logic [4:0] smp_q; // Bits sampled in this word
  logic [5:0] edg_q; // Master clock edges in this word
  logic [8:0] hp_q; // Half period counter
  logic [24:0] wc_q; // Inter-word wait counter
  logic sclk_q; // Master clock level
  logic loaded_q; // Slave word armed
  logic sprev_q; // Previous synced slave clock
  logic irq_q; // Registered interrupt request
  logic oe_q; // Clock pin drive enable
  logic [15:0] rdata_q; // Read data, one cycle after the strobe

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [2:0] pin_s; // {sclk, sdi, ss} after two flops
  spb_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw({sense.sclk, sense.sdi, sense.ss}),
    .synced(pin_s)
  );
  wire s_sclk = pin_s[2];
  wire s_sdi = pin_s[1];
  wire s_ss = pin_s[0];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire ena = ctl_q[SPB_ENA_BIT];
  wire master = ctl_q[SPB_MODE_BIT];
  wire cpol = ctl_q[SPB_CPOL_BIT];
  wire cpha = ctl_q[SPB_CPHA_BIT];
  wire [2:0] rate = ctl_q[SPB_RATE_LSB +: 3];
  wire [4:0] len = {1'b0, ctl_q[SPB_LEN_LSB +: 4]};
  wire wr_tx = bus.wr && hit(bus.addr, SPB_TX_DATA_OFS);
  wire rd_rx = bus.rd && hit(bus.addr, SPB_RX_DATA_OFS);
  // Pin polarity then pin/software source choice
  wire pin_sel = sel_q[SPB_SSP_BIT] ? s_ss : !s_ss;
  wire sel = sel_q[SPB_SSC_BIT] ? pin_sel : sel_q[SPB_SS_BIT];
  wire [8:0] half = SPB_HALF_BASE << rate;
  // Four-bit shift sum so rates 6 and 7 do not wrap to a short wait
  wire [3:0] wait_sh = {1'b0, rate} + 4'(SPB_PERIOD_SHIFT);
  wire [24:0] wait_len = 25'(wait_q) << wait_sh;
  // Master toggles its clock when the half period runs out
  wire m_ev = (st_q == M_XFER) && (hp_q == half - 9'h001);
  wire m_lead = m_ev && (sclk_q == cpol);
  wire m_trail = m_ev && (sclk_q != cpol);
  // Slave edges come from the synced clock; outside selection ignored
  wire s_act = ena && !master && sel && loaded_q;
  wire s_lead = s_act && (s_sclk != sprev_q) && (s_sclk != cpol);
  wire s_trail = s_act && (s_sclk != sprev_q) && (s_sclk == cpol);
  wire lead = master ? m_lead : s_lead;
  wire trail = master ? m_trail : s_trail;
  wire smp_ev = cpha ? trail : lead;
  // Shift only after the first sample, so phase 1 keeps its first bit
  wire sft_ev = (cpha ? lead : trail) && (smp_q != 5'h00);
  wire done = smp_ev && (smp_q == len);
  wire m_load = ena && master && (st_q == M_IDLE) && !tx_empty_flag_q;
  wire s_load = ena && !master && sel && !loaded_q;
  wire ld_buf = m_load || (s_load && !tx_empty_flag_q);
  wire [15:0] tx_al = txb_q << (4'hf - len[3:0]);
  wire m_last = m_ev && (edg_q == {len, 1'b1});
  // Masked receive view
  wire [15:0] rx_view = msk_q[SPB_RX_MASK_ENABLE_BIT] ?
      (rxb_q & low_mask(msk_q[SPB_RXMK_LSB +: 5])) : rxb_q;
  wire busy = (st_q != M_IDLE) || s_act;
  wire [15:0] stat = {9'h000, busy, 1'b0, tx_empty_flag_q, rx_overwrite_flag_q, rx_full_flag_q,
      2'b00};
  // Cause gating by individual and master enables
  wire cause = (int_q[SPB_TX_EMPTY_IRQ_ENABLE_BIT] && tx_empty_flag_q)
      || (int_q[SPB_RX_OVERWRITE_IRQ_ENABLE_BIT] && rx_overwrite_flag_q)
      || (int_q[SPB_RX_FULL_IRQ_ENABLE_BIT] && rx_full_flag_q);
  wire irq_d = int_q[SPB_IRQ_MASTER_ENABLE_BIT]
      && (cause || int_q[SPB_SIRQ_BIT]);
  // Read multiplexer; unmapped addresses read zero
  wire [15:0] rdata_d =
      hit(bus.addr, SPB_RX_DATA_OFS) ? rx_view :
      hit(bus.addr, SPB_TX_DATA_OFS) ? txb_q :
      hit(bus.addr, SPB_MAIN_CTL_OFS) ? ctl_q :
      hit(bus.addr, SPB_SEL_CTL_OFS) ? sel_q :
      hit(bus.addr, SPB_WAIT_OFS) ? wait_q :
      hit(bus.addr, SPB_STAT_OFS) ? stat :
      hit(bus.addr, SPB_INT_OFS) ? int_q :
      hit(bus.addr, SPB_MASK_OFS) ? msk_q : 16'h0000;

  // ----------------------------------------------------------------------
  // Register writes; masks keep reserved bits at zero
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Defaults after reset
      ctl_q <= SPB_CTL_RST;
      sel_q <= SPB_CTL_RST;
      wait_q <= SPB_CTL_RST;
      int_q <= SPB_CTL_RST;
      msk_q <= SPB_CTL_RST;
      txb_q <= SPB_CTL_RST;
    end
    else if (bus.wr)
    begin
      if (hit(bus.addr, SPB_MAIN_CTL_OFS))
        ctl_q <= bus.wdata & SPB_MAIN_CTL_WMASK;
      if (hit(bus.addr, SPB_SEL_CTL_OFS))
        sel_q <= bus.wdata & SPB_SEL_CTL_WMASK;
      if (hit(bus.addr, SPB_WAIT_OFS))
        wait_q <= bus.wdata;
      if (hit(bus.addr, SPB_INT_OFS))
        int_q <= bus.wdata & SPB_INT_WMASK;
      if (hit(bus.addr, SPB_MASK_OFS))
        msk_q <= bus.wdata & SPB_MASK_WMASK;
      if (wr_tx)
        txb_q <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags; a hardware set wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_empty_flag_q <= SPB_TX_EMPTY_FLAG_RST;
      rx_full_flag_q <= 1'b0;
      rx_overwrite_flag_q <= 1'b0;
    end
    else
    begin
      // Empty again once the word enters the shifter
      if (ld_buf)
        tx_empty_flag_q <= 1'b1;
      else if (wr_tx)
        tx_empty_flag_q <= 1'b0;
      // Full on every completed word
      if (done)
        rx_full_flag_q <= 1'b1;
      else if (rd_rx || !ena)
        rx_full_flag_q <= 1'b0;
      // Overwrite when a word lands on an unread one
      if (done && rx_full_flag_q)
        rx_overwrite_flag_q <= 1'b1;
      else if (rd_rx || !ena)
        rx_overwrite_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Shift registers and receive buffer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= 16'h0000;
      rx_q <= 16'h0000;
      rxb_q <= 16'h0000;
      smp_q <= 5'h00;
    end
    else if (m_load || s_load)
    begin
      // Slave underrun sends zeros rather than stale data
      sh_q <= tx_empty_flag_q ? 16'h0000 : tx_al;
      smp_q <= 5'h00;
    end
    else if (!ena || (!master && !sel))
      smp_q <= 5'h00;
    else
    begin
      if (sft_ev)
        sh_q <= {sh_q[14:0], 1'b0};
      if (smp_ev)
      begin
        rx_q <= {rx_q[14:0], s_sdi};
        smp_q <= smp_q + 5'h01;
      end
      // Bits above the word length read zero
      if (done)
        rxb_q <= {rx_q[14:0], s_sdi} & low_mask(len);
    end
  end

  // ----------------------------------------------------------------------
  // Master sequencer: clock generation and inter-word wait
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= M_IDLE;
      hp_q <= 9'h000;
      edg_q <= 6'h00;
      wc_q <= 25'h0000000;
      sclk_q <= 1'b0;
    end
    else if (!ena || !master)
    begin
      // Stopped: clock parked at its idle level
      st_q <= M_IDLE;
      sclk_q <= cpol;
      hp_q <= 9'h000;
      edg_q <= 6'h00;
    end
    else
    begin
      unique case (st_q)
        M_IDLE:
        begin
          sclk_q <= cpol;
          hp_q <= 9'h000;
          edg_q <= 6'h00;
          if (m_load)
            st_q <= M_XFER;
        end
        M_XFER:
        begin
          hp_q <= m_ev ? 9'h000 : hp_q + 9'h001;
          if (m_ev)
          begin
            sclk_q <= !sclk_q;
            edg_q <= edg_q + 6'h01;
          end
          if (m_last)
          begin
            // Zero wait goes straight back to idle
            wc_q <= wait_len;
            st_q <= (wait_q == 16'h0000) ? M_IDLE : M_WAIT;
          end
        end
        M_WAIT:
        begin
          wc_q <= wc_q - 25'h0000001;
          if (wc_q == 25'h0000001)
            st_q <= M_IDLE;
        end
        default:
          st_q <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Slave arming, outputs and read data
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loaded_q <= 1'b0;
      sprev_q <= 1'b0;
      irq_q <= 1'b0;
      oe_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      // Rearm after each word, drop on deselect or disable
      if (!ena || master || !sel || done)
        loaded_q <= 1'b0;
      else if (s_load)
        loaded_q <= 1'b1;
      sprev_q <= s_sclk;
      irq_q <= irq_d;
      oe_q <= ena && master;
      rdata_q <= bus.rd ? rdata_d : 16'h0000;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign drive.sclk = sclk_q;
  assign drive.sclk_oe = oe_q;
  assign drive.sdo = sh_q[15];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_irq_gate_off: assert property (
    !int_q[SPB_IRQ_MASTER_ENABLE_BIT] |=> !irq)
    else $error("interrupt raised with master enable clear");
  a_soft_irq_on: assert property (
    int_q[SPB_IRQ_MASTER_ENABLE_BIT] && int_q[SPB_SIRQ_BIT] |=> irq)
    else $error("software request not output");
  a_tx_empty_flag_write_clr: assert property (
    wr_tx && tx_empty_flag_q && !ld_buf |=> !tx_empty_flag_q)
    else $error("tx empty not cleared by write");
  a_tx_empty_flag_load_set: assert property (
    m_load |=> tx_empty_flag_q && busy)
    else $error("tx empty not set on load");
  a_rx_full_flag_on_done: assert property (
    done |=> rx_full_flag_q)
    else $error("rx full not set on completion");
  a_rx_overwrite_flag_overwrite: assert property (
    done && rx_full_flag_q |=> rx_overwrite_flag_q)
    else $error("overwrite flag not set");
  a_flags_disable: assert property (
    !ena && !done |=> !rx_full_flag_q && !rx_overwrite_flag_q)
    else $error("rx flags survive disable");
  a_mask_read: assert property (
    bus.rd && hit(bus.addr, SPB_RX_DATA_OFS) && msk_q[SPB_RX_MASK_ENABLE_BIT]
    |=> (rdata & ~low_mask($past(msk_q[SPB_RXMK_LSB +: 5]))) == 16'h0)
    else $error("masked receive bits not zero");
  a_stat_rsv_zero: assert property (
    bus.rd && hit(bus.addr, SPB_STAT_OFS)
    |=> rdata[15:7] == 9'h000 && rdata[5] == 1'b0
        && rdata[1:0] == 2'b00)
    else $error("status reserved bits not zero");
  a_wait_gap: assert property (
    st_q == M_WAIT && wc_q > 25'h1 |=> st_q == M_WAIT)
    else $error("wait cut short");

  c_master_word: cover property (m_load ##[1:600] done);
  c_overwrite: cover property (done && rx_full_flag_q);
  c_slave_word: cover property (s_load ##[1:600] done);

endmodule : spb_core

// [spb_peer.sv]
// Serial slave model facing the block while it runs as master
`timescale 1ns/100ps
module spb_peer (
  input wire logic load,
  input wire logic [15:0] word,
  input wire logic sclk,
  input wire logic sclk_oe,
  input wire logic sdo,
  output logic sdi,
  output logic [15:0] cap
);
  // Outgoing word, MSB leads
  logic [15:0] sr_q = 16'h0000;
  // ----------------------------------------------------------
  // Shift on trailing edge so data is long settled at leading
  // ----------------------------------------------------------
  always @(posedge load or negedge sclk)
  begin
    if (load)
      sr_q <= word;
    else
      sr_q <= {sr_q[14:0], ~sr_q[15]}; // Fill never repeats old data
  end
  // Capture the block's output on the leading edge
  always @(posedge sclk)
  begin
    cap <= {cap[14:0], sdo};
  end
  // Released line shows the inverse, not a stale level
  assign sdi = sclk_oe ? sr_q[15] : ~sr_q[15];
endmodule : spb_peer

// [spb_core_tb.sv]
// Self-checking bench of the serial port block
`timescale 1ns/100ps
`define CHK(n, e, a) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch %s exp %h got %h", n, e, a); \
    end \
  end
module spb_core_tb;
  import spb_pkg::*;
  logic ref_clk = 1'b0; // 40 MHz
  logic rst_n = 1'b0; // Async reset
  spb_bus_t bus = '0; // Register port
  logic ss_d = 1'b0; // Select pin level
  logic ssck = 1'b0; // Serial clock when the bench acts as master
  logic ssdi = 1'b0; // Serial data when the bench acts as master
  logic pload = 1'b0; // Peer word load
  logic [15:0] pword = 16'h0000; // Peer word
  logic [15:0] rdata, pcap, s;
  logic psdi, irq;
  spb_pin_in_t pin;
  spb_pin_out_t po;
  int fail_count = 0;
  int num_checks = 0;
  int cyc, last, gap, edges; // Serial clock monitor
  logic sclk_p = 1'b0;
  // Tables for register, interrupt and select cases
  logic [15:0] ra [4] = '{SPB_WAIT_OFS, SPB_SEL_CTL_OFS, SPB_MASK_OFS,
    16'h6060};
  logic [15:0] re [4] = '{16'hffff, 16'h0700, 16'h7c02, 16'h0000};
  logic [15:0] iv [5] = '{16'h0002, 16'h0003, 16'h0001, 16'h0011,
    16'h000d};
  logic ie [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [15:0] sv [7] = '{16'h0000, 16'h0400, 16'h0100, 16'h0100,
    16'h0300, 16'h0300, 16'h0500};
  logic sp [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic sb [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  // Peer answers while the block masters, the bench drives otherwise
  assign pin = {ssck, po.sclk_oe ? psdi : ssdi, ss_d};
  always #12.5 ref_clk = ~ref_clk;
  spb_core dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .sense(pin),
    .drive(po),
    .irq(irq)
  );
  spb_peer peer (
    .load(pload), .word(pword), .sclk(po.sclk), .sclk_oe(po.sclk_oe),
    .sdo(po.sdo), .sdi(psdi), .cap(pcap)
  );
  // Count serial clock toggles and the longest gap between them
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rst_n && po.sclk !== sclk_p)
    begin
      if (edges > 0 && cyc - last > gap)
        gap = cyc - last;
      edges++;
      last = cyc;
    end
    sclk_p = po.sclk;
  end
  // ----------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(posedge ref_clk);
    d = rdata; // Valid only in the cycle after the strobe
  endtask : rd
  task automatic rchk(input string n, input logic [15:0] a,
    input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK(n, e, d)
  endtask : rchk
  // Bounded wait on status bits
  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    for (int i = 0; i < 300; i++)
    begin
      rd(SPB_STAT_OFS, s);
      if ((s & m) === v)
        break;
    end
    `CHK("status wait", v, s & m)
  endtask : poll
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    rchk("wait", SPB_WAIT_OFS, 16'h0000);
    rchk("stat", SPB_STAT_OFS, 16'h0010);
    rchk("int", SPB_INT_OFS, 16'h0000);
    rchk("mask", SPB_MASK_OFS, 16'h0000);
    rchk("sel", SPB_SEL_CTL_OFS, 16'h0000);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      wr(ra[i], 16'hffff);
      rchk("reg", ra[i], re[i]);
      wr(ra[i], 16'h0000);
    end
    wr(SPB_STAT_OFS, 16'hffff);
    rchk("stat ro", SPB_STAT_OFS, 16'h0010);
    $display("test regs done");
  endtask : t_regs
  task automatic t_irq;
    for (int i = 0; i < 5; i++)
    begin
      wr(SPB_INT_OFS, iv[i]);
      rchk("int", SPB_INT_OFS, iv[i]);
      `CHK("irq", ie[i], irq)
    end
    wr(SPB_INT_OFS, 16'h0000);
    $display("test irq done");
  endtask : t_irq
  // Slave selection from the soft bit or the pin of either polarity
  task automatic t_slave;
    wr(SPB_MAIN_CTL_OFS, 16'h0001);
    wr(SPB_TX_DATA_OFS, 16'h0001);
    rchk("tx full", SPB_STAT_OFS, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      wr(SPB_SEL_CTL_OFS, sv[i]);
      ss_d <= sp[i];
      repeat (4) @(posedge ref_clk);
      rd(SPB_STAT_OFS, s);
      `CHK("selected", sb[i], s[SPB_BUSY_BIT])
    end
    `CHK("armed", 1'b1, s[SPB_TX_EMPTY_FLAG_BIT])
    wr(SPB_MAIN_CTL_OFS, 16'h0000);
    wr(SPB_SEL_CTL_OFS, 16'h0000);
    $display("test slave done");
  endtask : t_slave
  // Four-bit slave word clocked by the bench; data held across both edges
  task automatic t_sxfer(input logic [15:0] ctl);
    logic [3:0] got;
    logic [3:0] pat;
    logic pol;
    pat = 4'h6;
    pol = ctl[SPB_CPOL_BIT];
    ssck <= pol;
    wr(SPB_MAIN_CTL_OFS, ctl);
    wr(SPB_TX_DATA_OFS, 16'h000a);
    wr(SPB_SEL_CTL_OFS, 16'h0400);
    for (int i = 3; i >= 0; i--)
    begin
      ssdi <= pat[i];
      repeat (4) @(posedge ref_clk);
      if (!ctl[SPB_CPHA_BIT])
        got[i] = po.sdo;
      ssck <= !pol;
      repeat (4) @(posedge ref_clk);
      if (ctl[SPB_CPHA_BIT])
        got[i] = po.sdo;
      ssck <= pol;
      repeat (4) @(posedge ref_clk);
    end
    `CHK("slave sent", 4'ha, got)
    `CHK("slave no drive", 1'b0, po.sclk_oe)
    rchk("slave rx", SPB_RX_DATA_OFS, 16'h0006);
    wr(SPB_MAIN_CTL_OFS, 16'h0000);
    wr(SPB_SEL_CTL_OFS, 16'h0000);
    $display("test slave word done");
  endtask : t_sxfer
  task automatic peer_load(input logic [15:0] w);
    @(posedge ref_clk);
    pword <= w;
    pload <= 1'b1;
    @(posedge ref_clk);
    pload <= 1'b0;
    edges = 0;
    gap = 0;
  endtask : peer_load
  // Master: 8-bit words at rate 2, half period 8 clocks
  task automatic t_master;
    wr(SPB_INT_OFS, 16'h0005);
    wr(SPB_MAIN_CTL_OFS, 16'h1c23);
    peer_load(16'ha500);
    wr(SPB_TX_DATA_OFS, 16'h003c);
    poll(16'h0040, 16'h0040);
    poll(16'h0044, 16'h0004);
    `CHK("toggles", 16, edges)
    `CHK("half period", 8, gap)
    `CHK("irq full", 1'b1, irq)
    `CHK("sent", 8'h3c, pcap[7:0])
    `CHK("clock drive", 1'b1, po.sclk_oe)
    rchk("rx", SPB_RX_DATA_OFS, 16'h00a5);
    rchk("stat", SPB_STAT_OFS, 16'h0010);
    wr(SPB_WAIT_OFS, 16'h0002);
    peer_load(16'h5ac3);
    wr(SPB_TX_DATA_OFS, 16'h0081);
    poll(16'h0010, 16'h0010);
    wr(SPB_TX_DATA_OFS, 16'h007e);
    poll(16'h005c, 16'h001c);
    `CHK("toggles", 32, edges)
    `CHK("wait gap", 1'b1, gap >= 40 && gap <= 48)
    `CHK("sent", 16'h817e, pcap)
    wr(SPB_INT_OFS, 16'h0009);
    repeat (2) @(posedge ref_clk);
    `CHK("irq overwrite", 1'b1, irq)
    wr(SPB_MASK_OFS, 16'h0c02);
    rchk("rx masked", SPB_RX_DATA_OFS, 16'h0003);
    rchk("stat", SPB_STAT_OFS, 16'h0010);
    wr(SPB_MASK_OFS, 16'h0000);
    wr(SPB_WAIT_OFS, 16'h0000);
    wr(SPB_TX_DATA_OFS, 16'h0055);
    poll(16'h0044, 16'h0004);
    wr(SPB_MAIN_CTL_OFS, 16'h1c22);
    rchk("stat off", SPB_STAT_OFS, 16'h0010);
    `CHK("clock drive", 1'b0, po.sclk_oe)
    `CHK("irq", 1'b0, irq)
    wr(SPB_INT_OFS, 16'h0000);
    $display("test master done");
  endtask : t_master
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_irq();
    t_slave();
    t_sxfer(16'h0c01);
    t_sxfer(16'h0f01);
    t_master();
    complete_run();
  end
  // Watchdog well beyond the thousand or so cycles the tests need
  initial
  begin
    #2000000;
    fail_count++;
    complete_run();
  end
endmodule : spb_core_tb
